// *** logic/ptig_pkg.sv ***
// Shared constants and types for the periodic tick interrupt generator.
package ptig_pkg;

  // System clock period and the base time unit that every tick period is built from.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned UNIT_TIME_NS  = 10000;
  localparam int unsigned UNIT_CYC      = UNIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned UNIT_HALF_CYC = UNIT_CYC / 2;

  // Shortest tick period in microseconds and longest in seconds.
  localparam int unsigned MIN_PERIOD_US = 10;
  localparam int unsigned MAX_PERIOD_S  = 1200;

  localparam int unsigned STRAP_W  = 6;
  localparam int unsigned PERIOD_W = 27;
  localparam int unsigned PRE_W    = 7;
  localparam int unsigned SYNC_N   = 2;

  // Reset values.
  localparam logic [STRAP_W-1:0]  STRAP_RST  = 6'h00;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 27'h0000001;
  localparam logic [PRE_W-1:0]    PRE_RST    = 7'h00;

  // Period used for the seven codes that do not name a rate of their own.
  localparam logic [PERIOD_W-1:0] PERIOD_SPARE = 27'h3e8;

  typedef enum logic [1:0] {
    PTIG_IDLE    = 2'b01,
    PTIG_PENDING = 2'b10
  } ptig_irq_state_t;

  // Output of the time base: one pulse per period and the free-running square wave.
  typedef struct packed {
    logic tick;
    logic clk_level;
  } ptig_tick_t;

endpackage : ptig_pkg

// *** logic/ptig_rate_div.sv ***
// Free-running divider that turns the selected period into ticks and a square wave.
module ptig_rate_div (
  input  wire logic                            clk_sys_in,
  input  wire logic                            rstn_in,
  input  wire logic                            restart_in,
  input  wire logic [ptig_pkg::PERIOD_W-1:0]   period_in,
  output ptig_pkg::ptig_tick_t                 tick_out
);
  import ptig_pkg::*;

  logic [PRE_W-1:0]    pre_r;
  logic [PRE_W-1:0]    pre_nxt;
  logic [PERIOD_W-1:0] unit_r;
  logic [PERIOD_W-1:0] unit_nxt;
  logic                pre_wrap;
  logic                unit_wrap;
  logic                half_bit;
  logic [PERIOD_W:0]   half_pos;

  assign pre_wrap  = (pre_r == PRE_W'(UNIT_CYC - 1));
  assign unit_wrap = (unit_r >= period_in - PERIOD_W'(1));
  assign pre_nxt   = pre_wrap ? PRE_RST : pre_r + PRE_W'(1);
  assign unit_nxt  = !pre_wrap ? unit_r : (unit_wrap ? '0 : unit_r + PERIOD_W'(1));
  assign half_bit  = (pre_r >= PRE_W'(UNIT_HALF_CYC));
  assign half_pos  = {unit_r, half_bit};

  // The count never stops for enable or acknowledge, so the wave and ticks stay steady.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || restart_in) begin
      pre_r              <= PRE_RST;
      unit_r             <= '0;
      tick_out.tick      <= 1'b0;
      tick_out.clk_level <= 1'b0;
    end else begin
      pre_r              <= pre_nxt;
      unit_r             <= unit_nxt;
      tick_out.tick      <= pre_wrap && unit_wrap;
      tick_out.clk_level <= (half_pos < {1'b0, period_in});
    end
  end

endmodule : ptig_rate_div

// *** logic/ptig_irq.sv ***
// Pending-request state machine for the level 6 tick interrupt.
module ptig_irq (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic tick_in,
  input  wire logic enable_in,
  input  wire logic ack_in,
  output logic      pending_out
);
  import ptig_pkg::*;

  ptig_irq_state_t state_r;
  ptig_irq_state_t state_nxt;

  // A tick in the acknowledge cycle keeps the request, so no period is lost.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PTIG_IDLE: begin
        if (enable_in && tick_in) begin
          state_nxt = PTIG_PENDING;
        end
      end
      PTIG_PENDING: begin
        if (!enable_in) begin
          state_nxt = PTIG_IDLE;
        end else if (ack_in && !tick_in) begin
          state_nxt = PTIG_IDLE;
        end
      end
      default: begin
        state_nxt = PTIG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_r <= PTIG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pending_out = (state_r == PTIG_PENDING);

endmodule : ptig_irq

// *** logic/ptig_top.sv ***
// Top of the periodic tick interrupt generator: pin capture, rate table and outputs.
//
// How it works
// - Raise a level 6 autovectored request once per tick period while enabled.
// - Tick periods range from 10 microseconds up to 20 minutes.
// - Six straps pick the rate; 57 of 64 codes give distinct rates.
// - Enable line is active low; high suppresses, low allows tick requests.
// - The level 6 acknowledge vector fetch clears the pending request in hardware.
// - First request after enable comes at once or within one full period.
// - The time base runs free, never aligned to enable or system timing.
// - Requests continue at the chosen rate until reset or enable goes high.
// - A free-running clock at tick frequency always drives the port timer input.
// - The timer clock path is untouched by enable and acknowledge.
module ptig_top (
  input  wire logic                         clk_sys_in,
  input  wire logic                         rstn_in,
  input  wire logic [ptig_pkg::STRAP_W-1:0] rate_select_straps_in,
  input  wire logic                         tick_enable_n_in,
  input  wire logic                         iack6_in,
  output logic                              irq6_n_out,
  output logic                              port_timer_clock_in_out
);
  import ptig_pkg::*;

  // Rate table: code to period in 10 us units. Codes 57 to 63 have no rate of their own.
  function automatic logic [PERIOD_W-1:0] ptig_period(input logic [STRAP_W-1:0] code);
    logic [PERIOD_W-1:0] p;
    p = PERIOD_SPARE;
    case (code)
      6'h00: p = 27'h1;
      6'h01: p = 27'h2;
      6'h02: p = 27'h3;
      6'h03: p = 27'h4;
      6'h04: p = 27'h5;
      6'h05: p = 27'h6;
      6'h06: p = 27'ha;
      6'h07: p = 27'hc;
      6'h08: p = 27'h14;
      6'h09: p = 27'h1e;
      6'h0a: p = 27'h28;
      6'h0b: p = 27'h32;
      6'h0c: p = 27'h3c;
      6'h0d: p = 27'h64;
      6'h0e: p = 27'h78;
      6'h0f: p = 27'hc8;
      6'h10: p = 27'h12c;
      6'h11: p = 27'h190;
      6'h12: p = 27'h1f4;
      6'h13: p = 27'h258;
      6'h14: p = 27'h3e8;
      6'h15: p = 27'h4b0;
      6'h16: p = 27'h7d0;
      6'h17: p = 27'hbb8;
      6'h18: p = 27'hfa0;
      6'h19: p = 27'h1388;
      6'h1a: p = 27'h1770;
      6'h1b: p = 27'h2710;
      6'h1c: p = 27'h2ee0;
      6'h1d: p = 27'h4e20;
      6'h1e: p = 27'h7530;
      6'h1f: p = 27'h9c40;
      6'h20: p = 27'hc350;
      6'h21: p = 27'hf424;
      6'h22: p = 27'h186a0;
      6'h23: p = 27'h1d4c0;
      6'h24: p = 27'h30d40;
      6'h25: p = 27'h493e0;
      6'h26: p = 27'h61a80;
      6'h27: p = 27'h7a120;
      6'h28: p = 27'h927c0;
      6'h29: p = 27'hf4240;
      6'h2a: p = 27'h124f80;
      6'h2b: p = 27'h1e8480;
      6'h2c: p = 27'h2dc6c0;
      6'h2d: p = 27'h3d0900;
      6'h2e: p = 27'h4c4b40;
      6'h2f: p = 27'h5b8d80;
      6'h30: p = 27'h989680;
      6'h31: p = 27'hb71b00;
      6'h32: p = 27'h1312d00;
      6'h33: p = 27'h1c9c380;
      6'h34: p = 27'h2625a00;
      6'h35: p = 27'h2faf080;
      6'h36: p = 27'h3938700;
      6'h37: p = 27'h5f5e100;
      6'h38: p = 27'h7270e00;
      default: p = PERIOD_SPARE;
    endcase
    return p;
  endfunction : ptig_period

  // Two-stage capture for every pin; stage one is read by stage two only.
  localparam int unsigned PIN_W = STRAP_W + 2;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] sync_r;

  assign pin_raw = {iack6_in, tick_enable_n_in, rate_select_straps_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          meta_r[gi] <= (gi == STRAP_W) ? 1'b1 : 1'b0;
          sync_r[gi] <= (gi == STRAP_W) ? 1'b1 : 1'b0;
        end else begin
          meta_r[gi] <= pin_raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  logic [STRAP_W-1:0] strap_sync;
  logic               enable_n_sync;
  logic               iack_sync;

  assign strap_sync    = sync_r[STRAP_W-1:0];
  assign enable_n_sync = sync_r[STRAP_W];
  assign iack_sync     = sync_r[STRAP_W+1];

  // The straps are held in a register so the divider sees a steady period.
  logic [STRAP_W-1:0]  strap_r;
  logic                strap_valid_r;
  logic                strap_changed;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W-1:0] period_nxt;

  assign strap_changed = strap_valid_r && (strap_sync != strap_r);
  assign period_nxt    = ptig_period(strap_sync);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      strap_r       <= STRAP_RST;
      strap_valid_r <= 1'b0;
      period_r      <= PERIOD_RST;
    end else begin
      strap_r       <= strap_sync;
      strap_valid_r <= 1'b1;
      period_r      <= period_nxt;
    end
  end

  // Restarting on a new code avoids one wildly long period after a jumper move.
  logic restart;

  assign restart = strap_changed || !strap_valid_r;

  // The time base ignores enable entirely, so the first tick lands anywhere in a period.
  ptig_tick_t tb;

  ptig_rate_div u_rate_div (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .restart_in (restart),
    .period_in  (period_r),
    .tick_out   (tb)
  );

  // Acknowledge acts on its rising edge so a long vector fetch clears only once.
  logic iack_d_r;
  logic ack_edge;
  logic enabled;

  assign ack_edge = iack_sync && !iack_d_r;
  assign enabled  = !enable_n_sync;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      iack_d_r <= 1'b0;
    end else begin
      iack_d_r <= iack_sync;
    end
  end

  logic pending;

  ptig_irq u_irq (
    .clk_sys_in  (clk_sys_in),
    .rstn_in     (rstn_in),
    .tick_in     (tb.tick),
    .enable_in   (enabled),
    .ack_in      (ack_edge),
    .pending_out (pending)
  );

  // Both outputs leave through flip-flops so no decode glitch reaches a pin.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      irq6_n_out              <= 1'b1;
      port_timer_clock_in_out <= 1'b0;
    end else begin
      irq6_n_out              <= !pending;
      port_timer_clock_in_out <= tb.clk_level;
    end
  end

endmodule : ptig_top

// *** sim/ptig_top_props.sv ***
// Pin-level checker for the tick generator, bound onto its top.
module ptig_top_props (
  input wire logic                         clk_sys_in,
  input wire logic                         rstn_in,
  input wire logic [ptig_pkg::STRAP_W-1:0] rate_select_straps_in,
  input wire logic                         tick_enable_n_in,
  input wire logic                         iack6_in,
  input wire logic                         irq6_n_out,
  input wire logic                         port_timer_clock_in_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ptig_pkg::*;
  logic [8:0] age_r, run_r, gap_r, why_r;
  function automatic logic [8:0] inc(input logic [8:0] v);
    return (&v) ? v : v + 9'h001;
  endfunction : inc
  // Counters saturate, so the half-period checks stay quiet until over 300 or 500 cycles have passed since a strap change.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      {age_r, run_r, why_r} <= 27'h0000000;
      gap_r <= 9'h1ff;
    end else begin
      age_r <= $changed(rate_select_straps_in) ? 9'h000 : inc(age_r);
      run_r <= $changed(port_timer_clock_in_out) ? 9'h000 : inc(run_r);
      gap_r <= $fell(irq6_n_out) ? 9'h000 : inc(gap_r);
      why_r <= ($rose(iack6_in) || tick_enable_n_in) ? 9'h000 : inc(why_r);
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  property p_rst; $rose(rstn_in) |-> irq6_n_out && !port_timer_clock_in_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_off; tick_enable_n_in [*8] ##1 tick_enable_n_in [*8] |-> irq6_n_out; endproperty
  a_off: assert property (p_off) else $error("request while disabled");
  property p_ack; $rose(iack6_in) && !irq6_n_out |-> ##[1:8] irq6_n_out; endproperty
  a_ack: assert property (p_ack) else $error("fetch did not clear request");
  property p_tick;
    $fell(irq6_n_out) |-> !$past(port_timer_clock_in_out, 8) ##[0:3] port_timer_clock_in_out;
  endproperty
  a_tick: assert property (p_tick) else $error("request off the period edge");
  property p_half0;
    $changed(port_timer_clock_in_out) && rate_select_straps_in == 6'h00 && age_r > 9'h12c
      |-> run_r == 9'h031;
  endproperty
  a_half0: assert property (p_half0) else $error("code 0 half period wrong");
  property p_half1;
    $changed(port_timer_clock_in_out) && rate_select_straps_in == 6'h01 && age_r > 9'h1f4
      |-> run_r == 9'h063;
  endproperty
  a_half1: assert property (p_half1) else $error("code 1 half period wrong");
  property p_gap; $fell(irq6_n_out) |-> gap_r >= 9'h063; endproperty
  a_gap: assert property (p_gap) else $error("two requests in one period");
  property p_why; $rose(irq6_n_out) |-> why_r <= 9'h008; endproperty
  a_why: assert property (p_why) else $error("request dropped with no cause");
endmodule : ptig_top_props
bind ptig_top ptig_top_props u_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .rate_select_straps_in(rate_select_straps_in), .tick_enable_n_in(tick_enable_n_in),
  .iack6_in(iack6_in), .irq6_n_out(irq6_n_out),
  .port_timer_clock_in_out(port_timer_clock_in_out));

// *** sim/ptig_host.sv ***
// Host model: drives the enable line and answers requests with a vector fetch.
module ptig_host (
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  input  wire logic       en_want_in,
  input  wire logic       ack_on_in,
  input  wire logic [7:0] ack_dly_in,
  input  wire logic       irq6_n_in,
  output logic            tick_enable_n_out = 1'b1,
  output logic            iack6_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_r = 8'h00;
  always_ff @(posedge clk_sys_in) begin
    tick_enable_n_out <= !rstn_in || !en_want_in;
    if (!rstn_in || irq6_n_in || !ack_on_in) begin
      wait_r <= 8'h00;
    end else if (wait_r != 8'hff) begin
      wait_r <= wait_r + 8'h01;
    end
  end
  // The count saturates, so one request never gets a second fetch.
  assign iack6_out = (wait_r >= ack_dly_in) && (wait_r < ack_dly_in + 8'h03);
endmodule : ptig_host

// *** sim/tb_ptig_top.sv ***
// Self-checking bench for the periodic tick generator.
module tb_ptig_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ptig_pkg::*;
  logic               clk_sys_in = 1'b0;
  logic               rstn_in    = 1'b0;
  logic               en_want    = 1'b0;
  logic               ack_on     = 1'b1;
  logic [7:0]         ack_dly    = 8'h04;
  logic [STRAP_W-1:0] straps     = 6'h00;
  logic               tick_enable_n, iack6, irq6_n, wave;
  int                 failures = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  ptig_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .rate_select_straps_in(straps),
    .tick_enable_n_in(tick_enable_n), .iack6_in(iack6), .irq6_n_out(irq6_n),
    .port_timer_clock_in_out(wave));
  ptig_host host (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .en_want_in(en_want),
    .ack_on_in(ack_on), .ack_dly_in(ack_dly), .irq6_n_in(irq6_n),
    .tick_enable_n_out(tick_enable_n), .iack6_out(iack6));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic finish_test;
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // Waits for the wave (w=1) or the request (w=0) to reach lvl; n is the edges taken.
  task automatic wait_on(input bit w, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while ((w ? wave : irq6_n) !== lvl && n < lim);
  endtask : wait_on
  task automatic t_disabled;
    int rises;
    int lows;
    logic last;
    rises = 0;
    lows = 0;
    last = wave;
    repeat (300) begin
      @(posedge clk_sys_in);
      lows += int'(irq6_n !== 1'b1);
      rises += int'(wave === 1'b1 && last === 1'b0);
      last = wave;
    end
    chk(lows == 0, "request while disabled");
    chk(rises == 3, "timer clock stalled");
  endtask : t_disabled
  task automatic t_period(input logic [STRAP_W-1:0] code, input int p);
    int a;
    int b;
    int c;
    straps <= code;
    repeat (20) @(posedge clk_sys_in);
    en_want <= 1'b1;
    wait_on(0, 0, p + 20, a);
    chk(a <= p + 12, "first request late");
    wait_on(0, 1, p, a);
    wait_on(0, 0, p, b);
    chk(a + b == p, "request interval");
    // Align on a rising edge first, so each count covers a whole half period.
    wait_on(1, 0, p, a);
    wait_on(1, 1, p, a);
    wait_on(1, 0, p, b);
    wait_on(1, 1, p, c);
    chk(b == p / 2 && c == p / 2, "timer clock period");
    en_want <= 1'b0;
  endtask : t_period
  task automatic t_ack;
    int n;
    straps <= 6'h01;
    ack_dly <= 8'h28;
    // Let the previous disable take hold, so the next request is a fresh one.
    repeat (10) @(posedge clk_sys_in);
    en_want <= 1'b1;
    wait_on(0, 0, 260, n);
    repeat (30) @(posedge clk_sys_in);
    chk(irq6_n === 1'b0, "cleared before fetch");
    wait_on(0, 1, 20, n);
    chk(irq6_n === 1'b1, "fetch did not clear");
    ack_on <= 1'b0;
    wait_on(0, 0, 220, n);
    repeat (250) @(posedge clk_sys_in);
    chk(irq6_n === 1'b0, "request lost");
    en_want <= 1'b0;
    wait_on(0, 1, 12, n);
    chk(irq6_n === 1'b1, "disable kept request");
  endtask : t_ack
  // A mid-run system reset must drop a standing request and restart disabled.
  task automatic t_reset;
    int n;
    en_want <= 1'b1;
    wait_on(0, 0, 260, n);
    chk(irq6_n === 1'b0, "no request before reset");
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk(irq6_n === 1'b1 && tick_enable_n === 1'b1, "reset left ticks on");
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    chk(irq6_n === 1'b1 && wave === 1'b0, "not idle after reset");
    en_want <= 1'b0;
  endtask : t_reset
  // The full run needs about 6300 cycles.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 15000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    chk(irq6_n === 1'b1 && wave === 1'b0, "not idle after reset");
    t_disabled();
    t_period(6'h00, 100);
    t_period(6'h01, 200);
    t_period(6'h06, 1000);
    t_ack();
    t_reset();
    finish_test();
  end
endmodule : tb_ptig_top
